// ==== dv/fpb_button_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Push button on the front panel, active low
// ---------------------------------------------
module fpb_button_model (
   input wire logic pclk,
   output logic button_n
);
   // Contacts chatter once before settling, so the debounce is exercised
   task automatic press(input int cyc);
      button_n <= 1'b0;
      @(posedge pclk) button_n <= 1'b1;
      @(posedge pclk) button_n <= 1'b0;
      repeat (cyc) @(posedge pclk);
      button_n <= 1'b1;
   endtask
   // A pull-up holds the line high at rest
   initial button_n = 1'b1;
endmodule

// ==== dv/fpb_front_panel_monitor.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Indicator and address-server checks
// ---------------------------------------------
module fpb_front_panel_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [6:0] sig_strength,
   input wire logic link_up,
   input wire logic [7:0] client_count,
   input wire logic wlan_ready,
   input wire logic boot_busy,
   input wire logic ap_assoc,
   input wire logic [2:0] sig_led,
   input wire logic [2:0] cli_led,
   input wire logic pair_led,
   input wire logic dhcp_en
);
   logic [2:0] ctrl;
   logic sg, cl;
   // Shadow of the enable register, taken only on a completed write
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ctrl <= 3'h7;
      else if (psel && penable && pready && pwrite && paddr == 8'h00)
         ctrl <= pwdata[2:0];
   // Bars may light at all; startup is left out since its display is open
   assign sg = !boot_busy && link_up && ctrl[0] && sig_strength != 7'h00;
   assign cl = !boot_busy && wlan_ready && ctrl[1] && client_count != 8'h00;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sig_high; sg && sig_strength >= 7'h32 |=> sig_led == 3'h7; endproperty
   a_sig_high: assert property (p_sig_high) else $error("signal bar not full");
   property p_sig_mid; sg && sig_strength inside {[7'h19:7'h31]} |=> sig_led == 3'h3; endproperty
   a_sig_mid: assert property (p_sig_mid) else $error("signal bar not two");
   property p_sig_low; sg && sig_strength < 7'h19 |=> sig_led == 3'h1; endproperty
   a_sig_low: assert property (p_sig_low) else $error("signal bar not one");
   property p_sig_off; !boot_busy && !sg |=> sig_led == 3'h0; endproperty
   a_sig_off: assert property (p_sig_off) else $error("signal bar not dark");
   property p_cli_many; cl && client_count >= 8'h0A |=> cli_led == 3'h1; endproperty
   a_cli_many: assert property (p_cli_many) else $error("client bar not one");
   property p_cli_mid; cl && client_count inside {[5:9]} |=> cli_led == 3'h3; endproperty
   a_cli_mid: assert property (p_cli_mid) else $error("client bar not two");
   property p_cli_few; cl && client_count < 8'h05 |=> cli_led == 3'h7; endproperty
   a_cli_few: assert property (p_cli_few) else $error("client bar not three");
   property p_cli_off; !boot_busy && !cl |=> cli_led == 3'h0; endproperty
   a_cli_off: assert property (p_cli_off) else $error("client bar not dark");
   property p_pair_off; !ctrl[2] |=> !pair_led; endproperty
   a_pair_off: assert property (p_pair_off) else $error("pairing lamp lit");
   property p_dhcp; 1'b1 |=> dhcp_en == !$past(ap_assoc); endproperty
   a_dhcp: assert property (p_dhcp) else $error("address server state wrong");
endmodule

// ==== dv/fpb_front_panel_test.sv ====
`timescale 1ns/1ps
module fpb_front_panel_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, button_n, rerr;
   logic [7:0] paddr, client_count;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] sig_strength;
   logic link_up, wlan_ready, boot_busy, pair_ok, pair_fail, ap_assoc, pair_led, dhcp_en;
   logic ap_pair_start, cli_pair_start, pair_abort, reboot_req, factory_req;
   logic [2:0] sig_led, cli_led, c;
   logic [4:0] req;
   int bad_count, checks_done, cyc, i, s, n;
   int ts[7] = '{0, 1, 24, 25, 49, 50, 100};
   int tn[7] = '{0, 1, 4, 5, 9, 10, 255};
   // Long durations shortened: one millisecond tick is four clocks
   fpb_front_panel #(.MS_TICK_CYCLES(4), .DEBOUNCE_TICKS(2), .GAP_TICKS(20),
      .HOLD_REBOOT_TICKS(50), .HOLD_FACTORY_TICKS(100), .SESSION_TICKS(300),
      .SUCCESS_TICKS(400), .FAIL_TICKS(100)) u_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .button_n, .sig_strength,
      .link_up, .client_count, .wlan_ready, .boot_busy, .pair_ok, .pair_fail, .ap_assoc,
      .sig_led, .cli_led, .pair_led, .ap_pair_start, .cli_pair_start, .pair_abort,
      .reboot_req, .factory_req, .dhcp_en);
   fpb_button_model u_btn (.pclk, .button_n);
   // ---------------------------------------------
   // Clock, hang guard and shared tasks
   // ---------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // A hang counts as a mismatch and ends the run
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         results();
      end
   end
   task results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   // Request held until pready is sampled high, then released
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task st(input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, 8'h08, 32'h0);
      chk("status", e, rd & m);
   endtask
   task rst();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   // Request pulses stand one cycle, so every cycle is looked at
   task req_wait(input logic [4:0] e, input int lim);
      req = 5'h0;
      for (int k = 0; k < lim && req == 5'h0; k++)
      begin
         @(posedge pclk);
         req = {ap_pair_start, cli_pair_start, pair_abort, reboot_req, factory_req};
      end
      chk("request", e, req);
   endtask
   task presses(input int p);
      repeat (p)
      begin
         u_btn.press(20);
         repeat (40) @(posedge pclk);
      end
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      void'($urandom(32'h47d9));
      {psel, penable, pair_ok, pair_fail, presetn} = '0;
      {pwrite, paddr, pwdata, ap_assoc, sig_strength, link_up, client_count, wlan_ready} =
         59'({$urandom, $urandom});
      boot_busy = 1'b1;
      rst();
      st(32'h7, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h7, rd & 32'h7);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", 1'b1, rerr);
      apb(1'b1, 8'h08, 32'h7);
      chk("status write", 1'b1, rerr);
      boot_busy <= 1'b0;
      repeat (2) @(posedge pclk);
      st(32'h7, 32'h0);
      $display("end of register test");
      // Boundary values first, then random ones; enables vary every eighth turn
      c = 3'h7;
      for (i = 0; i < 48; i++)
      begin
         if (i % 8 == 7)
         begin
            c = 3'($urandom_range(7));
            apb(1'b1, 8'h00, {29'h0, c});
         end
         s = (i < 7) ? ts[i] : $urandom_range(100);
         n = (i < 7) ? tn[i] : $urandom_range(255);
         sig_strength <= 7'(s);
         client_count <= 8'(n);
         link_up <= (i < 7) | 1'($urandom);
         wlan_ready <= (i < 7) | 1'($urandom);
         ap_assoc <= 1'($urandom);
         repeat (2) @(posedge pclk);
         chk("sig_led", (!c[0] || !link_up || s == 0) ? 0 : s >= 50 ? 7 : s >= 25 ? 3 : 1,
            sig_led);
         chk("cli_led", (!c[1] || !wlan_ready || n == 0) ? 0 : n >= 10 ? 1 : n >= 5 ? 3 : 7,
            cli_led);
         chk("dhcp_en", !ap_assoc, dhcp_en);
      end
      apb(1'b1, 8'h00, 32'h7);
      $display("end of indicator test");
      u_btn.press(120);
      req_wait(5'b10000, 600);
      st(32'h7, 32'h2);
      pair_ok <= 1'b1;
      @(posedge pclk) pair_ok <= 1'b0;
      st(32'h7, 32'h3);
      chk("pair_led", 1'b1, pair_led);
      repeat (1540) @(posedge pclk);
      st(32'h7, 32'h3);
      repeat (100) @(posedge pclk);
      st(32'h7, 32'h0);
      $display("end of upstream test");
      presses(2);
      req_wait(5'b01000, 600);
      st(32'h8, 32'h8);
      presses(2);
      apb(1'b1, 8'h04, 32'h1);
      presses(1);
      repeat (80) @(posedge pclk);
      st(32'h70F, 32'h308);
      $display("end of client test");
      apb(1'b1, 8'h04, 32'h1);
      pair_fail <= 1'b1;
      @(posedge pclk) pair_fail <= 1'b0;
      st(32'h7, 32'h4);
      u_btn.press(20);
      req_wait(5'b10000, 600);
      req_wait(5'b00100, 1400);
      st(32'h7, 32'h4);
      $display("end of timeout test");
      u_btn.press(240);
      req_wait(5'b00010, 100);
      st(32'h7, 32'h1);
      rst();
      u_btn.press(440);
      req_wait(5'b00001, 100);
      rst();
      $display("end of hold test");
      results();
   end
endmodule
bind fpb_front_panel fpb_front_panel_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .sig_strength, .link_up, .client_count, .wlan_ready, .boot_busy,
   .ap_assoc, .sig_led, .cli_led, .pair_led, .dhcp_en);

// ==== rtl/fpb_front_panel.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Signal LEDs show three, two or one lit for 50-100, 25-49, below 25 percent.
// - Signal LEDs dark without signal, when unlinked, or when disabled by software.
// - Ten or more associated clients light exactly one client LED.
// - Five to nine associated clients light two client LEDs.
// - One to four associated clients light three client LEDs.
// - Client LEDs dark while wireless LAN not ready or no clients.
// - Pairing LED stays steadily on for five minutes after success.
// - Pairing LED blinks normally while a session waits for a peer.
// - Pairing LED blinks slowly during startup, reboot or reset.
// - Pairing LED blinks rapidly when upstream pairing fails.
// - Pairing LED off with no session, after five minutes, or disabled.
// - Single press or hold under five seconds starts upstream pairing.
// - Two presses start pairing toward a wireless client.
// - Hold of five to ten seconds requests reboot keeping configuration.
// - Hold over ten seconds requests factory restore then reboot.
// - Three presses turn pairing LED off, drop client session, resume normal.
// - Physical button requests win over conflicting software pairing requests.
// - A session stays open two minutes, then ends unsuccessful without peer.
// - Address server enabled until upstream association, disabled afterwards.
module fpb_front_panel #(
   parameter int MS_TICK_CYCLES = fpb_pkg::MS_CYCLES,
   parameter int DEBOUNCE_TICKS = fpb_pkg::DEBOUNCE_MS,
   parameter int GAP_TICKS = fpb_pkg::GAP_MS,
   parameter int HOLD_REBOOT_TICKS = fpb_pkg::HOLD_REBOOT_MS,
   parameter int HOLD_FACTORY_TICKS = fpb_pkg::HOLD_FACTORY_MS,
   parameter int SESSION_TICKS = fpb_pkg::SESSION_MS,
   parameter int SUCCESS_TICKS = fpb_pkg::SUCCESS_MS,
   parameter int FAIL_TICKS = fpb_pkg::FAIL_MS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic button_n,
   input wire logic [6:0] sig_strength,
   input wire logic link_up,
   input wire logic [7:0] client_count,
   input wire logic wlan_ready,
   input wire logic boot_busy,
   input wire logic pair_ok,
   input wire logic pair_fail,
   input wire logic ap_assoc,
   output logic [2:0] sig_led,
   output logic [2:0] cli_led,
   output logic pair_led,
   output logic ap_pair_start,
   output logic cli_pair_start,
   output logic pair_abort,
   output logic reboot_req,
   output logic factory_req,
   output logic dhcp_en
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Number of lit segments to a three-LED bar pattern
   function automatic logic [2:0] fpb_bar(input logic [1:0] n);
      return 3'((4'h1 << n) - 4'h1);            // Thermometer code, lowest LED first
   endfunction

   // ----------------------------------------------------------------
   // Millisecond timebase
   // ----------------------------------------------------------------
   logic [15:0] presc;
   logic ms_tick;
   logic [10:0] blink_cnt;
   wire presc_wrap = (presc == 16'(MS_TICK_CYCLES - 1));

   // Every duration below is counted in these ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presc <= 16'h0000;
         ms_tick <= 1'b0;
         blink_cnt <= 11'h000;
      end
      else
      begin
         presc <= presc_wrap ? 16'h0000 : presc + 16'h0001;
         ms_tick <= presc_wrap;
         blink_cnt <= blink_cnt + 11'(ms_tick);
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic [2:0] ctrl;
   logic [31:0] status_word;
   wire setup_ph = psel && !penable;
   wire wr_done = psel && penable && pready && pwrite;
   wire hit_ctrl = (paddr == fpb_pkg::CTRL_OFS);
   wire hit_cmd = (paddr == fpb_pkg::CMD_OFS);
   wire hit_status = (paddr == fpb_pkg::STATUS_OFS);
   wire mapped = hit_ctrl || hit_cmd || (hit_status && !pwrite);
   wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl} : (hit_status ? status_word : 32'h0);
   // Command bits act once, at the completing edge of the write
   wire sw_ap = wr_done && hit_cmd && pwdata[fpb_pkg::CMD_AP_BIT];
   wire sw_cli = wr_done && hit_cmd && pwdata[fpb_pkg::CMD_CLI_BIT];
   wire sw_cancel = wr_done && hit_cmd && pwdata[fpb_pkg::CMD_CANCEL_BIT];

   // Zero wait states: ready and read data are prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup_ph;
         pslverr <= setup_ph && !mapped;
         prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Control register: indicator enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= fpb_pkg::CTRL_RESET;
      end
      else if (wr_done && hit_ctrl)
      begin
         ctrl <= pwdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Button debounce
   // ----------------------------------------------------------------
   logic btn_db;
   logic [7:0] deb_cnt;
   wire btn_raw = !button_n;
   wire deb_done = (deb_cnt == 8'(DEBOUNCE_TICKS));

   // Level must stay changed for the whole debounce time
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         btn_db <= 1'b0;
         deb_cnt <= 8'h00;
      end
      else if (btn_raw == btn_db)
      begin
         deb_cnt <= 8'h00;
      end
      else if (deb_done)
      begin
         btn_db <= btn_raw;
         deb_cnt <= 8'h00;
      end
      else
      begin
         deb_cnt <= deb_cnt + 8'(ms_tick);
      end
   end

   // ----------------------------------------------------------------
   // Gesture classification
   // ----------------------------------------------------------------
   logic btn_prev;
   logic [13:0] hold_ms;
   logic [9:0] gap_ms;
   logic [1:0] press_cnt;
   logic [2:0] last_act;
   wire btn_fall = btn_prev && !btn_db;
   wire hold_factory = (hold_ms > 14'(HOLD_FACTORY_TICKS));
   wire hold_reboot = !hold_factory && (hold_ms >= 14'(HOLD_REBOOT_TICKS));
   wire short_rel = btn_fall && !hold_factory && !hold_reboot;
   wire gap_end = !btn_db && (press_cnt != 2'h0) && (gap_ms == 10'(GAP_TICKS));
   // Long holds act on release
   wire g_factory = btn_fall && hold_factory;
   wire g_reboot = btn_fall && hold_reboot;
   // Short gestures act only when the gap has run out
   wire g_ap = gap_end && (press_cnt == 2'h1);
   wire g_cli = gap_end && (press_cnt == 2'h2);
   wire g_cancel = gap_end && (press_cnt == 2'h3);
   wire btn_busy = btn_db || (press_cnt != 2'h0);

   // Hold timer saturates just above the factory threshold
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         btn_prev <= 1'b0;
         hold_ms <= 14'h0000;
      end
      else
      begin
         btn_prev <= btn_db;
         if (!btn_db)
         begin
            hold_ms <= 14'h0000;
         end
         else if (ms_tick && !hold_factory)
         begin
            hold_ms <= hold_ms + 14'h0001;
         end
      end
   end

   // Press counter and inter-press gap; a long hold discards earlier presses
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         press_cnt <= 2'h0;
         gap_ms <= 10'h000;
      end
      else if (gap_end || g_factory || g_reboot)
      begin
         press_cnt <= 2'h0;
         gap_ms <= 10'h000;
      end
      else if (short_rel)
      begin
         press_cnt <= (press_cnt == 2'h3) ? 2'h3 : press_cnt + 2'h1;
         gap_ms <= 10'h000;
      end
      else if (btn_db)
      begin
         gap_ms <= 10'h000;
      end
      else if (press_cnt != 2'h0)
      begin
         gap_ms <= gap_ms + 10'(ms_tick);
      end
   end

   // Record of the last decided gesture, for software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_act <= fpb_pkg::ACT_NONE;
      end
      else if (g_factory)
      begin
         last_act <= fpb_pkg::ACT_FACTORY;
      end
      else if (g_reboot)
      begin
         last_act <= fpb_pkg::ACT_REBOOT;
      end
      else if (g_ap)
      begin
         last_act <= fpb_pkg::ACT_AP;
      end
      else if (g_cli)
      begin
         last_act <= fpb_pkg::ACT_CLI;
      end
      else if (g_cancel)
      begin
         last_act <= fpb_pkg::ACT_CANCEL;
      end
   end

   // ----------------------------------------------------------------
   // Request arbitration
   // ----------------------------------------------------------------
   // Software is heard only while the button is idle, so a held or
   // half-finished gesture can never be overridden from the bus
   wire sw_ok = !btn_busy;
   wire go_ap = g_ap || (sw_ok && sw_ap && !sw_cli);
   wire go_cli = g_cli || (sw_ok && sw_cli);
   wire go_cancel = g_cancel || (sw_ok && sw_cancel && !sw_ap && !sw_cli);
   wire go_reset = g_factory || g_reboot;

   // ----------------------------------------------------------------
   // Pairing indicator state
   // ----------------------------------------------------------------
   fpb_pkg::fpb_pair_state_t pst;
   fpb_pkg::fpb_pair_state_t next_pst;
   logic [18:0] pst_ms;
   logic cli_mode;
   logic reset_pend;
   wire start = go_ap || go_cli;
   wire sess_over = (pst_ms >= 19'(SESSION_TICKS));
   wire succ_over = (pst_ms >= 19'(SUCCESS_TICKS));
   wire fail_over = (pst_ms >= 19'(FAIL_TICKS));

   // Boot and pending reboot take precedence over any pairing activity
   always_comb
   begin
      next_pst = pst;
      unique case (pst)
         fpb_pkg::FPB_PS_OFF:
         begin
            if (start)
            begin
               next_pst = fpb_pkg::FPB_PS_WAIT;
            end
         end
         fpb_pkg::FPB_PS_BOOT:
         begin
            if (!boot_busy && !reset_pend)
            begin
               next_pst = fpb_pkg::FPB_PS_OFF;
            end
         end
         fpb_pkg::FPB_PS_WAIT:
         begin
            if (go_cancel)
            begin
               next_pst = fpb_pkg::FPB_PS_OFF;
            end
            else if (pair_ok)
            begin
               next_pst = fpb_pkg::FPB_PS_ON;
            end
            else if (pair_fail || sess_over)
            begin
               // Upstream failure is shown; a client session just ends
               next_pst = cli_mode ? fpb_pkg::FPB_PS_OFF : fpb_pkg::FPB_PS_FAIL;
            end
         end
         fpb_pkg::FPB_PS_ON:
         begin
            if (start)
            begin
               next_pst = fpb_pkg::FPB_PS_WAIT;
            end
            else if (go_cancel || succ_over)
            begin
               next_pst = fpb_pkg::FPB_PS_OFF;
            end
         end
         fpb_pkg::FPB_PS_FAIL:
         begin
            if (start)
            begin
               next_pst = fpb_pkg::FPB_PS_WAIT;
            end
            else if (go_cancel || fail_over)
            begin
               next_pst = fpb_pkg::FPB_PS_OFF;
            end
         end
      endcase
      if (boot_busy || reset_pend || go_reset)
      begin
         next_pst = fpb_pkg::FPB_PS_BOOT;
      end
   end

   // State timer restarts on every change of state, and on a restart of waiting
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pst <= fpb_pkg::FPB_PS_BOOT;
         pst_ms <= 19'h00000;
      end
      else
      begin
         pst <= next_pst;
         if ((next_pst != pst) || (start && next_pst == fpb_pkg::FPB_PS_WAIT))
         begin
            pst_ms <= 19'h00000;
         end
         else if (ms_tick && !(&pst_ms))
         begin
            pst_ms <= pst_ms + 19'h00001;
         end
      end
   end

   // Session direction, and a reboot latch that only reset clears
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cli_mode <= 1'b0;
         reset_pend <= 1'b0;
      end
      else
      begin
         if (start && next_pst == fpb_pkg::FPB_PS_WAIT)
         begin
            cli_mode <= go_cli;
         end
         if (go_reset)
         begin
            reset_pend <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Indicator decode
   // ----------------------------------------------------------------
   wire [1:0] sig_lvl = (sig_strength >= fpb_pkg::SIG_HIGH_PCT) ? 2'h3 :
                        (sig_strength >= fpb_pkg::SIG_MID_PCT) ? 2'h2 : 2'h1;
   wire sig_dark = (sig_strength == 7'h00) || !link_up ||
                   !ctrl[fpb_pkg::CTRL_SIG_EN_BIT];
   wire [1:0] cli_lvl = (client_count >= fpb_pkg::CLI_MANY) ? 2'h1 :
                        (client_count >= fpb_pkg::CLI_SOME) ? 2'h2 : 2'h3;
   wire cli_dark = !wlan_ready || (client_count == 8'h00) ||
                   !ctrl[fpb_pkg::CTRL_CLI_EN_BIT];
   wire blink_slow = blink_cnt[fpb_pkg::BLINK_SLOW_BIT];
   wire blink_norm = blink_cnt[fpb_pkg::BLINK_NORM_BIT];
   wire blink_fast = blink_cnt[fpb_pkg::BLINK_FAST_BIT];
   wire pair_pat = (pst == fpb_pkg::FPB_PS_ON) ||
                   (pst == fpb_pkg::FPB_PS_WAIT && blink_norm) ||
                   (pst == fpb_pkg::FPB_PS_BOOT && blink_slow) ||
                   (pst == fpb_pkg::FPB_PS_FAIL && blink_fast);
   wire pair_lit = pair_pat && ctrl[fpb_pkg::CTRL_PAIR_EN_BIT];

   // All panel outputs are registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sig_led <= 3'h0;
         cli_led <= 3'h0;
         pair_led <= 1'b0;
         dhcp_en <= 1'b1;
      end
      else
      begin
         sig_led <= sig_dark ? 3'h0 : fpb_bar(sig_lvl);
         cli_led <= cli_dark ? 3'h0 : fpb_bar(cli_lvl);
         pair_led <= pair_lit;
         dhcp_en <= !ap_assoc;
      end
   end

   // One-cycle request pulses to the system controller
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ap_pair_start <= 1'b0;
         cli_pair_start <= 1'b0;
         pair_abort <= 1'b0;
         reboot_req <= 1'b0;
         factory_req <= 1'b0;
      end
      else
      begin
         ap_pair_start <= go_ap && !go_cli && !reset_pend;
         cli_pair_start <= go_cli && !reset_pend;
         pair_abort <= go_cancel || (pst == fpb_pkg::FPB_PS_WAIT && sess_over);
         reboot_req <= g_reboot;
         factory_req <= g_factory;
      end
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[fpb_pkg::ST_STATE_LSB +: 3] = pst;
      status_word[fpb_pkg::ST_CLIMODE_BIT] = cli_mode;
      status_word[fpb_pkg::ST_DHCP_BIT] = dhcp_en;
      status_word[fpb_pkg::ST_BTN_BIT] = btn_db;
      status_word[fpb_pkg::ST_PRESS_LSB +: 2] = press_cnt;
      status_word[fpb_pkg::ST_LAST_LSB +: 3] = last_act;
   end

endmodule

// ==== rtl/fpb_pkg.sv ====
package fpb_pkg;
   // -----------------------------------------------------------------
   // Clock and timebase
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / 1000;  // Cycles per millisecond tick

   // -----------------------------------------------------------------
   // Durations, each in its own unit and then in millisecond ticks
   // -----------------------------------------------------------------
   localparam int DEBOUNCE_MS = 20;
   localparam int GAP_MS = 400;                 // Inter-press gap closing a gesture
   localparam int HOLD_REBOOT_S = 5;
   localparam int HOLD_FACTORY_S = 10;
   localparam int SESSION_MIN = 2;
   localparam int SUCCESS_MIN = 5;
   localparam int FAIL_S = 10;                  // How long the failure pattern shows
   localparam int HOLD_REBOOT_MS = HOLD_REBOOT_S * MS_PER_S;
   localparam int HOLD_FACTORY_MS = HOLD_FACTORY_S * MS_PER_S;
   localparam int SESSION_MS = SESSION_MIN * 60 * MS_PER_S;
   localparam int SUCCESS_MS = SUCCESS_MIN * 60 * MS_PER_S;
   localparam int FAIL_MS = FAIL_S * MS_PER_S;

   // Blink phases are bits of a free-running millisecond counter
   localparam int BLINK_SLOW_BIT = 10;          // About 1 s on, 1 s off
   localparam int BLINK_NORM_BIT = 8;           // About 256 ms half period
   localparam int BLINK_FAST_BIT = 6;           // About 64 ms half period

   // -----------------------------------------------------------------
   // Indicator thresholds
   // -----------------------------------------------------------------
   localparam logic [6:0] SIG_HIGH_PCT = 7'h32;  // 50 percent
   localparam logic [6:0] SIG_MID_PCT = 7'h19;   // 25 percent
   localparam logic [7:0] CLI_MANY = 8'h0A;      // Ten clients
   localparam logic [7:0] CLI_SOME = 8'h05;      // Five clients

   // -----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam int CTRL_SIG_EN_BIT = 0;
   localparam int CTRL_CLI_EN_BIT = 1;
   localparam int CTRL_PAIR_EN_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h7;
   localparam int CMD_AP_BIT = 0;
   localparam int CMD_CLI_BIT = 1;
   localparam int CMD_CANCEL_BIT = 2;
   localparam int ST_STATE_LSB = 0;             // Pairing indicator state, 3 bits
   localparam int ST_CLIMODE_BIT = 3;
   localparam int ST_DHCP_BIT = 4;
   localparam int ST_BTN_BIT = 5;
   localparam int ST_PRESS_LSB = 6;             // Presses gathered so far, 2 bits
   localparam int ST_LAST_LSB = 8;              // Last gesture action, 3 bits

   // Gesture action codes as reported in the status register
   localparam logic [2:0] ACT_NONE = 3'h0;
   localparam logic [2:0] ACT_AP = 3'h1;
   localparam logic [2:0] ACT_CLI = 3'h2;
   localparam logic [2:0] ACT_CANCEL = 3'h3;
   localparam logic [2:0] ACT_REBOOT = 3'h4;
   localparam logic [2:0] ACT_FACTORY = 3'h5;

   typedef enum logic [2:0] {
      FPB_PS_OFF,
      FPB_PS_BOOT,
      FPB_PS_WAIT,
      FPB_PS_ON,
      FPB_PS_FAIL
   } fpb_pair_state_t;
endpackage
